// *** rtl/scl_pkg.sv ***
// Constants and types for the strap configuration latch.
// Assumes a 32-bit AXI4-Lite register port and a 50 MHz system clock.
package scl_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int STRAP_ADDR_W = 5;
    localparam int MODE_W       = 3;
    localparam int LED_N        = 4;
    localparam int NIB_W        = 4;
    localparam int AXI_AW       = 8;
    localparam int AXI_DW       = 32;
    localparam int CFG_W        = 16;

    // ************************************************************
    // Control and advertisement field positions
    // ************************************************************
    localparam int CTRL_SPEED   = 13;
    localparam int CTRL_AUTONEG = 12;
    localparam int CTRL_PDOWN   = 11;
    localparam int CTRL_ISOLATE = 10;
    localparam int CTRL_DUPLEX  = 8;
    localparam int ADV_LSB      = 5;
    localparam logic [CFG_W-1:0] CTRL_WMASK = 16'h3D00;
    localparam logic [CFG_W-1:0] ADV_WMASK  = 16'h01E0;

    // ************************************************************
    // Mode strap codes and their defaults
    // ************************************************************
    localparam logic [MODE_W-1:0] MODE_10HD     = 3'h0;
    localparam logic [MODE_W-1:0] MODE_10FD     = 3'h1;
    localparam logic [MODE_W-1:0] MODE_100HD    = 3'h2;
    localparam logic [MODE_W-1:0] MODE_100FD    = 3'h3;
    localparam logic [MODE_W-1:0] MODE_AN_100HD = 3'h4;
    localparam logic [MODE_W-1:0] MODE_REPEATER = 3'h5;
    localparam logic [MODE_W-1:0] MODE_PDOWN    = 3'h6;
    localparam logic [MODE_W-1:0] MODE_ALL      = 3'h7;
    // CTL nibbles are {speed, autoneg, isolate, duplex}; ADV nibbles are ability bits
    localparam logic [NIB_W-1:0] CTL_10HD     = 4'h0;
    localparam logic [NIB_W-1:0] CTL_10FD     = 4'h1;
    localparam logic [NIB_W-1:0] CTL_100HD    = 4'h8;
    localparam logic [NIB_W-1:0] CTL_100FD    = 4'h9;
    localparam logic [NIB_W-1:0] CTL_AN_100HD = 4'hC;
    localparam logic [NIB_W-1:0] CTL_ALL      = 4'hD;
    localparam logic [NIB_W-1:0] CTL_NONE     = 4'h0;
    localparam logic [NIB_W-1:0] ADV_100HD    = 4'h4;
    localparam logic [NIB_W-1:0] ADV_ALL      = 4'hF;
    localparam logic [NIB_W-1:0] ADV_NONE     = 4'h0;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [AXI_AW-1:0] REG_CTRL_OFS = 8'h00;
    localparam logic [AXI_AW-1:0] REG_ADV_OFS  = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STAT_OFS = 8'h08;
    localparam int STAT_ADDR_LSB = 0;
    localparam int STAT_MODE_LSB = 8;
    localparam int STAT_READY    = 16;
    localparam int STAT_PDOWN    = 17;
    localparam int STAT_REP      = 18;
    localparam int STAT_CRS      = 19;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {SEL_CTRL, SEL_ADV, SEL_STAT, SEL_NONE}
        scl_sel_e;
    typedef enum logic {LD_HELD, LD_RUN} scl_ld_e;
    typedef struct packed {
        logic [NIB_W-1:0] ctl;
        logic [NIB_W-1:0] adv;
        logic             pdown;
        logic             rep;
        logic             crs_tx;
    } scl_dflt_s;

endpackage : scl_pkg

// *** rtl/scl_sync.sv ***
// Two-stage synchroniser for a group of slow pin levels.
// Assumes the inputs are quasi-static straps or a reset pin.
`timescale 1ns/100ps
module scl_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  logic             clk,
    input  logic             reset,
    // Pin side and clock side
    input  logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } scl_sync_s;

    scl_sync_s r;
    scl_sync_s n;

    // First stage feeds only the second stage
    always_comb begin
        n    = r;
        n.s1 = pins;
        n.s2 = r.s1;
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign synced = r.s2;

endmodule : scl_sync

// *** rtl/scl_strap_latch.sv ***
// Strap configuration latch: captures address and mode straps at the
// release of the hardware reset pin and serves them to the core.
// Assumes an AXI4-Lite master on SYS_CLK and a frame engine on SYS_CLK.
//
// Operation
// - Latch address straps at reset release, hold.
// - Accept only frames matching latched address, ignore the rest.
// - Latched address seeds the transmit scrambler.
// - Mode 000: 10M half, no autoneg.
// - Mode 001: 10M full, no autoneg.
// - Mode 010: 100M half, CRS on tx.
// - Mode 011: 100M full, CRS rx only.
// - Mode 100: autoneg advertising 100M half only.
// - Mode 101: repeater, autoneg, CRS rx only.
// - Mode 110: wake directly into power-down.
// - Mode 111: autoneg advertising all abilities.
// - LED polarity from matching address strap bit.
`timescale 1ns/100ps
module scl_strap_latch
    import scl_pkg::*;
(
    // Clock and reset
    input  logic                    SYS_CLK,
    input  logic                    RESET,
    // Strap pins
    input  logic                    HW_RESET_N,
    input  logic [STRAP_ADDR_W-1:0] ADDRESS_STRAPS,
    input  logic [MODE_W-1:0]       MODE_STRAPS,
    // Management frame engine
    input  logic                    FRAME_VALID,
    input  logic [STRAP_ADDR_W-1:0] FRAME_ADDR,
    output logic                    FRAME_ACCEPT,
    output logic                    FRAME_IGNORE,
    // LEDs
    input  logic [LED_N-1:0]        LED_STATE,
    output logic [LED_N-1:0]        LED_PINS,
    // Core configuration
    output logic                    SPEED_100,
    output logic                    AUTONEG_EN,
    output logic                    POWER_DOWN,
    output logic                    ISOLATE,
    output logic                    FULL_DUPLEX,
    output logic [NIB_W-1:0]        ADVERT_ABILITY,
    output logic                    REPEATER_MODE,
    output logic                    CRS_ON_TX,
    output logic [STRAP_ADDR_W-1:0] SCRAMBLER_SEED,
    output logic                    CONFIG_LOADED,
    // AXI4-Lite slave
    input  logic [AXI_AW-1:0]       S_AXI_AWADDR,
    input  logic                    S_AXI_AWVALID,
    output logic                    S_AXI_AWREADY,
    input  logic [AXI_DW-1:0]       S_AXI_WDATA,
    input  logic [AXI_DW/8-1:0]     S_AXI_WSTRB,
    input  logic                    S_AXI_WVALID,
    output logic                    S_AXI_WREADY,
    output logic [1:0]              S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  logic                    S_AXI_BREADY,
    input  logic [AXI_AW-1:0]       S_AXI_ARADDR,
    input  logic                    S_AXI_ARVALID,
    output logic                    S_AXI_ARREADY,
    output logic [AXI_DW-1:0]       S_AXI_RDATA,
    output logic [1:0]              S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  logic                    S_AXI_RREADY
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Register select, shared by the write and read paths
    function automatic scl_sel_e reg_sel(input logic [AXI_AW-1:0] a);
        if (a == REG_CTRL_OFS) begin
            return SEL_CTRL;
        end else if (a == REG_ADV_OFS) begin
            return SEL_ADV;
        end else if (a == REG_STAT_OFS) begin
            return SEL_STAT;
        end
        return SEL_NONE;
    endfunction : reg_sel

    // Byte-lane merge limited to the writable bits
    function automatic logic [CFG_W-1:0] merge(
        input logic [CFG_W-1:0]    old,
        input logic [AXI_DW-1:0]   d,
        input logic [AXI_DW/8-1:0] s,
        input logic [CFG_W-1:0]    m
    );
        logic [CFG_W-1:0] v;
        v = old;
        for (int b = 0; b < CFG_W / 8; b++) begin
            if (s[b]) begin
                v[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return v & m;
    endfunction : merge

    // Strap mode to reset defaults
    function automatic scl_dflt_s mode_dflt(input logic [MODE_W-1:0] m);
        scl_dflt_s d;
        d = '{CTL_NONE, ADV_NONE, 1'b0, 1'b0, 1'b0};
        unique case (m)
            MODE_10HD:     d = '{CTL_10HD, ADV_NONE, 1'b0, 1'b0, 1'b1};
            MODE_10FD:     d = '{CTL_10FD, ADV_NONE, 1'b0, 1'b0, 1'b0};
            MODE_100HD:    d = '{CTL_100HD, ADV_NONE, 1'b0, 1'b0, 1'b1};
            MODE_100FD:    d = '{CTL_100FD, ADV_NONE, 1'b0, 1'b0, 1'b0};
            MODE_AN_100HD: d = '{CTL_AN_100HD, ADV_100HD, 1'b0, 1'b0, 1'b1};
            MODE_REPEATER: d = '{CTL_AN_100HD, ADV_100HD, 1'b0, 1'b1, 1'b0};
            MODE_PDOWN:    d = '{CTL_NONE, ADV_NONE, 1'b1, 1'b0, 1'b0};
            MODE_ALL:      d = '{CTL_ALL, ADV_ALL, 1'b0, 1'b0, 1'b1};
        endcase
        return d;
    endfunction : mode_dflt

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        scl_ld_e                 st;
        logic                    ready;
        logic                    pin_d;
        logic [STRAP_ADDR_W-1:0] addr;
        logic [MODE_W-1:0]       mode;
        logic [CFG_W-1:0]        ctrl;
        logic [CFG_W-1:0]        adv;
        logic                    rep;
        logic                    crs_tx;
        logic [LED_N-1:0]        led;
        logic                    acc;
        logic                    ign;
        logic                    aw_rdy;
        logic                    w_rdy;
        logic                    aw_have;
        logic                    w_have;
        logic [AXI_AW-1:0]       awaddr;
        logic [AXI_DW-1:0]       wdata;
        logic [AXI_DW/8-1:0]     wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    ar_rdy;
        logic                    rvalid;
        logic [AXI_DW-1:0]       rdata;
        logic [1:0]              rresp;
    } scl_state_s;

    scl_state_s              state_r;
    scl_state_s              state_nxt;
    logic                    pin_s;
    logic [STRAP_ADDR_W-1:0] addr_s;
    logic [MODE_W-1:0]       mode_s;
    logic                    rise_w;
    scl_dflt_s               dflt_w;

    // Straps and reset pin pass two flops before any logic
    scl_sync #(
        .WIDTH(1 + STRAP_ADDR_W + MODE_W)
    ) u_sync (
        .clk   (SYS_CLK),
        .reset (RESET),
        .pins  ({HW_RESET_N, ADDRESS_STRAPS, MODE_STRAPS}),
        .synced({pin_s, addr_s, mode_s})
    );

    // Release edge of the synchronised reset pin
    assign rise_w = pin_s & ~state_r.pin_d;
    assign dflt_w = mode_dflt(mode_s);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_nxt       = state_r;
        state_nxt.pin_d = pin_s;
        state_nxt.acc   = 1'b0;
        state_nxt.ign   = 1'b0;
        // Frames are only judged once defaults are in place
        if (FRAME_VALID && state_r.ready) begin
            if (FRAME_ADDR == state_r.addr) begin
                state_nxt.acc = 1'b1;
            end else begin
                state_nxt.ign = 1'b1;
            end
        end
        // LED polarity: strap 1 gives active low
        state_nxt.led = LED_STATE ^ state_r.addr[LED_N-1:0];
        // Write channel; address and data may come in either order
        if (S_AXI_AWVALID && state_r.aw_rdy) begin
            state_nxt.aw_have = 1'b1;
            state_nxt.awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && state_r.w_rdy) begin
            state_nxt.w_have = 1'b1;
            state_nxt.wdata  = S_AXI_WDATA;
            state_nxt.wstrb  = S_AXI_WSTRB;
        end
        if (state_r.bvalid && S_AXI_BREADY) begin
            state_nxt.bvalid = 1'b0;
        end
        if (state_nxt.aw_have && state_nxt.w_have && !state_nxt.bvalid) begin
            state_nxt.aw_have = 1'b0;
            state_nxt.w_have  = 1'b0;
            state_nxt.bvalid  = 1'b1;
            state_nxt.bresp   = RESP_OKAY;
            unique case (reg_sel(state_nxt.awaddr))
                SEL_CTRL: state_nxt.ctrl = merge(state_r.ctrl,
                    state_nxt.wdata, state_nxt.wstrb, CTRL_WMASK);
                SEL_ADV:  state_nxt.adv = merge(state_r.adv,
                    state_nxt.wdata, state_nxt.wstrb, ADV_WMASK);
                SEL_STAT: state_nxt.bresp = RESP_OKAY;
                SEL_NONE: state_nxt.bresp = RESP_SLVERR;
            endcase
        end
        // Each ready only while its own channel has nothing parked and no response is pending, which stalls the master
        state_nxt.aw_rdy = !state_nxt.aw_have && !state_nxt.bvalid;
        state_nxt.w_rdy  = !state_nxt.w_have && !state_nxt.bvalid;
        // Read channel, one read in flight
        if (state_r.rvalid && S_AXI_RREADY) begin
            state_nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && state_r.ar_rdy) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp  = RESP_OKAY;
            state_nxt.rdata  = '0;
            unique case (reg_sel(S_AXI_ARADDR))
                SEL_CTRL: state_nxt.rdata[CFG_W-1:0] = state_r.ctrl;
                SEL_ADV:  state_nxt.rdata[CFG_W-1:0] = state_r.adv;
                SEL_STAT: begin
                    state_nxt.rdata[STAT_ADDR_LSB +: STRAP_ADDR_W] =
                        state_r.addr;
                    state_nxt.rdata[STAT_MODE_LSB +: MODE_W] = state_r.mode;
                    state_nxt.rdata[STAT_READY] = state_r.ready;
                    state_nxt.rdata[STAT_PDOWN] = state_r.ctrl[CTRL_PDOWN];
                    state_nxt.rdata[STAT_REP]   = state_r.rep;
                    state_nxt.rdata[STAT_CRS]   = state_r.crs_tx;
                end
                SEL_NONE: state_nxt.rresp = RESP_SLVERR;
            endcase
        end
        state_nxt.ar_rdy = !state_nxt.rvalid;
        // Loader last, so a reset release beats a same-cycle write
        if (!pin_s) begin
            state_nxt.st    = LD_HELD;
            state_nxt.ready = 1'b0;
        end else if (rise_w) begin
            state_nxt.st   = LD_RUN;
            state_nxt.ready = 1'b1;
            state_nxt.addr = addr_s;
            state_nxt.mode = mode_s;
            state_nxt.ctrl = '0;
            state_nxt.ctrl[CTRL_SPEED]   = dflt_w.ctl[3];
            state_nxt.ctrl[CTRL_AUTONEG] = dflt_w.ctl[2];
            state_nxt.ctrl[CTRL_ISOLATE] = dflt_w.ctl[1];
            state_nxt.ctrl[CTRL_DUPLEX]  = dflt_w.ctl[0];
            state_nxt.ctrl[CTRL_PDOWN]   = dflt_w.pdown;
            state_nxt.adv = '0;
            state_nxt.adv[ADV_LSB +: NIB_W] = dflt_w.adv;
            state_nxt.rep    = dflt_w.rep;
            state_nxt.crs_tx = dflt_w.crs_tx;
        end
    end

    // State register; frame judging idles until the pin is released, while the AXI and LED paths run
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    assign FRAME_ACCEPT   = state_r.acc;
    assign FRAME_IGNORE   = state_r.ign;
    assign LED_PINS       = state_r.led;
    assign SPEED_100      = state_r.ctrl[CTRL_SPEED];
    assign AUTONEG_EN     = state_r.ctrl[CTRL_AUTONEG];
    assign POWER_DOWN     = state_r.ctrl[CTRL_PDOWN];
    assign ISOLATE        = state_r.ctrl[CTRL_ISOLATE];
    assign FULL_DUPLEX    = state_r.ctrl[CTRL_DUPLEX];
    assign ADVERT_ABILITY = state_r.adv[ADV_LSB +: NIB_W];
    assign REPEATER_MODE  = state_r.rep;
    assign CRS_ON_TX      = state_r.crs_tx;
    assign SCRAMBLER_SEED = state_r.addr;
    assign CONFIG_LOADED  = state_r.ready;
    assign S_AXI_AWREADY  = state_r.aw_rdy;
    assign S_AXI_WREADY   = state_r.w_rdy;
    assign S_AXI_BVALID   = state_r.bvalid;
    assign S_AXI_BRESP    = state_r.bresp;
    assign S_AXI_ARREADY  = state_r.ar_rdy;
    assign S_AXI_RVALID   = state_r.rvalid;
    assign S_AXI_RDATA    = state_r.rdata;
    assign S_AXI_RRESP    = state_r.rresp;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    logic [NIB_W-1:0] nib_w;
    assign nib_w = {SPEED_100, AUTONEG_EN, ISOLATE, FULL_DUPLEX};

    a_addr_hold: assert property (
        CONFIG_LOADED && $past(CONFIG_LOADED) |-> $stable(SCRAMBLER_SEED))
        else $error("latched address changed while running");
    a_frame_match: assert property (
        FRAME_VALID && CONFIG_LOADED && FRAME_ADDR == SCRAMBLER_SEED
        |=> FRAME_ACCEPT && !FRAME_IGNORE)
        else $error("matching frame not accepted");
    a_seed_capture: assert property (
        rise_w |=> SCRAMBLER_SEED == $past(addr_s) && CONFIG_LOADED)
        else $error("scrambler seed not taken from straps");
    a_mode_10hd: assert property (
        rise_w && mode_s == MODE_10HD |=> nib_w == CTL_10HD && CRS_ON_TX)
        else $error("mode 000 defaults wrong");
    a_mode_10fd: assert property (
        rise_w && mode_s == MODE_10FD |=> nib_w == CTL_10FD)
        else $error("mode 001 defaults wrong");
    a_mode_100hd: assert property (
        rise_w && mode_s == MODE_100HD |=> nib_w == CTL_100HD && CRS_ON_TX)
        else $error("mode 010 defaults wrong");
    a_mode_100fd: assert property (
        rise_w && mode_s == MODE_100FD |=> nib_w == CTL_100FD && !CRS_ON_TX)
        else $error("mode 011 defaults wrong");
    a_mode_an_hd: assert property (
        rise_w && mode_s == MODE_AN_100HD |=> nib_w == CTL_AN_100HD
        && ADVERT_ABILITY == ADV_100HD && CRS_ON_TX && !REPEATER_MODE)
        else $error("mode 100 defaults wrong");
    a_mode_repeat: assert property (
        rise_w && mode_s == MODE_REPEATER |=> nib_w == CTL_AN_100HD
        && ADVERT_ABILITY == ADV_100HD && !CRS_ON_TX && REPEATER_MODE)
        else $error("mode 101 defaults wrong");
    a_mode_pdown: assert property (
        rise_w && mode_s == MODE_PDOWN |=> POWER_DOWN)
        else $error("mode 110 did not wake in power-down");
    a_mode_all: assert property (
        rise_w && mode_s == MODE_ALL |=> AUTONEG_EN && !ISOLATE
        && ADVERT_ABILITY == ADV_ALL && !POWER_DOWN)
        else $error("mode 111 defaults wrong");
    a_led_polarity: assert property (
        CONFIG_LOADED && $past(CONFIG_LOADED) |->
        LED_PINS == ($past(LED_STATE) ^ SCRAMBLER_SEED[LED_N-1:0]))
        else $error("LED polarity does not follow strap");
    a_no_early_ans: assert property (
        !CONFIG_LOADED |=> !FRAME_ACCEPT && !FRAME_IGNORE)
        else $error("frame answered before defaults loaded");

endmodule : scl_strap_latch

// *** sim/scl_mgmt_model.sv ***
// Partner model: board straps, the hardware reset pin and management frames.
// Assumes it shares SYS_CLK with the latch; the bench calls its tasks.
`timescale 1ns/100ps
module scl_mgmt_model
    import scl_pkg::*;
(
    // Clock
    input  logic                    clk,
    // Straps and frames
    output logic                    hw_reset_n,
    output logic [STRAP_ADDR_W-1:0] address_straps,
    output logic [MODE_W-1:0]       mode_straps,
    output logic                    frame_valid,
    output logic [STRAP_ADDR_W-1:0] frame_addr
);
    // Pin held low from power-up until the bench releases it
    initial begin
        hw_reset_n = 1'b0;
        address_straps = 5'h00;
        mode_straps = 3'h0;
        frame_valid = 1'b0;
        frame_addr = 5'h1F;
    end
    // This task changes straps only while the pin is low, so they are steady at release
    task automatic pin_reset(input logic [4:0] a, input logic [2:0] m);
        @(posedge clk);
        hw_reset_n <= 1'b0;
        address_straps <= a;
        mode_straps <= m;
        repeat (6) @(posedge clk);
        hw_reset_n <= 1'b1;
    endtask : pin_reset
    // Deliberate strap disturbance, used only to show the latch ignores it
    task automatic bump_straps();
        @(posedge clk);
        address_straps <= ~address_straps;
        mode_straps <= ~mode_straps;
    endtask : bump_straps
    // One frame address, then a gap as long as a real frame at slow MDC
    task automatic frame(input logic [4:0] a);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_addr <= a;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_addr <= ~a; // Released field no longer shows the address
        repeat (20) @(posedge clk);
    endtask : frame
endmodule : scl_mgmt_model

// *** sim/tb_strap_config_latch.sv ***
// Self-checking bench for the strap configuration latch.
// Assumes the partner model drives straps, the reset pin and frames.
`timescale 1ns/100ps
module tb_strap_config_latch
    import scl_pkg::*;
;
    logic SYS_CLK = 1'b0, RESET = 1'b1;
    logic [3:0] led_state = 4'h0, wstrb = 4'hF, led, adv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic hw_n, fv, acc, ign, spd, an, pd, iso, fd, rep, crs, ldd;
    logic awr, wr, bv, arr, rv;
    logic [4:0] sa, fa, seed;
    logic [2:0] sm;
    logic [1:0] bresp, rresp;
    int err_count = 0, checks = 0;
    logic [33:0] rq[$];
    logic [1:0] fq[$], bq[$];

    always #10 SYS_CLK = ~SYS_CLK;

    scl_mgmt_model mdl (.clk(SYS_CLK), .hw_reset_n(hw_n),
        .address_straps(sa), .mode_straps(sm), .frame_valid(fv),
        .frame_addr(fa));

    scl_strap_latch uut (.SYS_CLK(SYS_CLK), .RESET(RESET), .HW_RESET_N(hw_n),
        .ADDRESS_STRAPS(sa), .MODE_STRAPS(sm), .FRAME_VALID(fv),
        .FRAME_ADDR(fa), .FRAME_ACCEPT(acc), .FRAME_IGNORE(ign),
        .LED_STATE(led_state), .LED_PINS(led), .SPEED_100(spd),
        .AUTONEG_EN(an), .POWER_DOWN(pd), .ISOLATE(iso), .FULL_DUPLEX(fd),
        .ADVERT_ABILITY(adv), .REPEATER_MODE(rep), .CRS_ON_TX(crs),
        .SCRAMBLER_SEED(seed), .CONFIG_LOADED(ldd),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));

    // Comparison with a four-state match so an unknown never passes
    task automatic check(input string n, input logic [33:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // Expected {control nibble, advert nibble, power-down, repeater, crs}
    function automatic logic [10:0] exp_cfg(input logic [2:0] m);
        case (m)
            3'h0: return {4'h0, 4'h0, 3'h1};
            3'h1: return {4'h1, 4'h0, 3'h0};
            3'h2: return {4'h8, 4'h0, 3'h1};
            3'h3: return {4'h9, 4'h0, 3'h0};
            3'h4: return {4'hC, 4'h4, 3'h1};
            3'h5: return {4'hC, 4'h4, 3'h2};
            3'h6: return {4'h0, 4'h0, 3'h4};
            default: return {4'hD, 4'hF, 3'h1};
        endcase
    endfunction : exp_cfg

    // Write: both channels offered together, each released when taken
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        bq.push_back(er);
        @(posedge SYS_CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (awr) awvalid <= 1'b0;
            if (wr) wvalid <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
    endtask : wr_reg

    // Read: the monitor compares the answer against the queued note
    task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge SYS_CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (arr) arvalid <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
    endtask : rd_reg

    // Monitor: an unexpected frame pulse meets an empty queue and fails
    always @(posedge SYS_CLK) begin
        if (acc || ign) begin
            if (fq.size() == 0) begin
                check("frame", {acc, ign}, 2'h0);
            end else begin
                check("frame", {acc, ign}, fq.pop_front());
            end
        end
        if (bv && bready) begin
            check("bresp", bresp, bq.pop_front());
        end
        if (rv && rready) begin
            check("read", {rresp, rdata}, rq.pop_front());
        end
    end

    task automatic complete_run();
        $display("Checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (8000) @(posedge SYS_CLK);
        err_count++;
        complete_run();
    end

    // Every mode, then mode 0 again after register writes to see reload
    initial begin
        logic [4:0]  a;
        logic [2:0]  m;
        logic [10:0] e;
        void'($urandom(32'h153B));
        repeat (12) @(posedge SYS_CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            a = 5'($urandom);
            m = i[2:0];
            e = exp_cfg(m);
            mdl.pin_reset(a, m);
            mdl.frame(a); // Lands before the load, so no answer
            check("cfg", {spd, an, pd, iso, fd, adv, rep, crs, seed, ldd},
            {e[10:9], e[2], e[8:7], e[6:3], e[1:0], a, 1'b1});
            fq.push_back(2'h2);
            mdl.frame(a);
            fq.push_back(2'h1);
            mdl.frame(a ^ 5'($urandom_range(31, 1)));
            @(posedge SYS_CLK);
            led_state <= 4'($urandom);
            repeat (2) @(posedge SYS_CLK);
            check("led", led, led_state ^ a[3:0]);
            rd_reg(REG_STAT_OFS, {2'h0, 12'h000, e[0], e[1], e[2], 1'b1,
                5'h00, m, 3'h0, a});
            rd_reg(REG_CTRL_OFS, {2'h0, 16'h0000, 2'h0, e[10:9], e[2], e[8],
                1'b0, e[7], 8'h00});
            rd_reg(REG_ADV_OFS, {2'h0, 23'h0, e[6:3], 5'h00});
            mdl.bump_straps();
            repeat (5) @(posedge SYS_CLK);
            check("seed", seed, a);
            if (i == 7) begin
                wr_reg(REG_CTRL_OFS, 32'hFFFFFFFF, RESP_OKAY);
                rd_reg(REG_CTRL_OFS, {2'h0, 32'h00003D00});
                check("ctl", {spd, an, pd, iso, fd}, 5'h1F);
                wr_reg(8'h0C, 32'h12345678, RESP_SLVERR);
                rd_reg(8'h0C, {RESP_SLVERR, 32'h0});
            end
        end
        complete_run();
    end
endmodule : tb_strap_config_latch
